/* shared/pilc_regs.vh */
// register offsets, field positions, reset values and timing counts
`ifndef PILC_REGS_VH
`define PILC_REGS_VH
`define PILC_ADDR_EN_LO 8'h3a
`define PILC_ADDR_EN_HI 8'h3b
`define PILC_ADDR_PL_LO 8'h3c
`define PILC_ADDR_PL_HI 8'h3d
`define PILC_BIT_MASTER 0
`define PILC_BIT_TRAP 2
`define PILC_BIT_WDOG 3
`define PILC_BIT_EXT0 4
`define PILC_BIT_SHARED 14
`define PILC_EN_RESET 16'h0000
`define PILC_PL_RESET 16'h0000
`define PILC_VEC_RESET 16'hfffe
`define PILC_VEC_SWTRAP 16'hfffc
`define PILC_VEC_TRAP 16'hfffa
`define PILC_VEC_WDOG 16'hfff8
`define PILC_VEC_EXT0 16'hfff6
`define PILC_ACCEPT_CYCLES 4'h8
`endif

/* tb/pilc_cpu_model.sv */
// cpu core stand-in: instruction boundaries and the stacked master enable
`timescale 1ns/1ps
module pilc_cpu_model
(
    input wire mclk_i,
    input wire rst_i,
    input wire busy_o,
    input wire push_o,
    input wire [1:0] push_sel_o,
    input wire push_master_o,
    output reg instr_done_o,
    output reg stacked_master_o
);
    reg [1:0] cnt_q; // cycle within a four-cycle instruction
    // boundary pulse ends each instruction; held off while accepting
    always @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cnt_q <= 2'h0;
            instr_done_o <= 1'b0;
            stacked_master_o <= 1'b0;
        end
        else
        begin
            cnt_q <= busy_o ? 2'h0 : cnt_q + 2'h1;
            instr_done_o <= !busy_o && cnt_q == 2'h3;
            if (push_o && push_sel_o == 2'h0)
                stacked_master_o <= push_master_o;
        end
    end
endmodule

/* tb/pilc_top_props.sv */
// port-level assertion checker for the interrupt latch controller
`timescale 1ns/1ps
module pilc_props
(
    input wire mclk_i,
    input wire rst_i,
    input wire sfr_rd_i,
    input wire [7:0] sfr_addr_i,
    input wire [7:0] sfr_rdata_o,
    input wire [15:0] enable_o,
    input wire busy_o,
    input wire [15:0] vector_o,
    input wire push_o,
    input wire [1:0] push_sel_o,
    input wire push_master_o,
    input wire vector_load_o
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (rst_i);
    // master enable output is clear one cycle after the sequence shows busy
    property p_master_clr;
        $rose(busy_o) |=> !enable_o[0];
    endproperty
    a_master_clr: assert property (p_master_clr) else $error("master kept");
    // three pushes in order: status, pc high, pc low
    property p_push_order;
        $rose(busy_o) |=> push_o && push_sel_o == 2'h0
            ##1 push_o && push_sel_o == 2'h1 ##1 push_o && push_sel_o == 2'h2;
    endproperty
    a_push_order: assert property (p_push_order) else $error("push order");
    // no fourth push, so the stack moves by three only
    property p_push_count;
        $rose(busy_o) |-> ##4 !push_o [*5];
    endproperty
    a_push_count: assert property (p_push_count) else $error("extra push");
    // vector lands eight cycles after the accept edge, seven after busy
    property p_accept_len;
        $rose(busy_o) |-> ##7 vector_load_o;
    endproperty
    a_accept_len: assert property (p_accept_len) else $error("length");
    // busy ends in the same cycle the vector load pulses
    property p_busy_end;
        vector_load_o |=> !busy_o;
    endproperty
    a_busy_end: assert property (p_busy_end) else $error("busy stuck");
    // with master saved as zero only a non-maskable vector may follow
    property p_nonmask;
        push_o && push_sel_o == 2'h0 && !push_master_o |-> ##7 vector_o >= 16'hfff8;
    endproperty
    a_nonmask: assert property (p_nonmask) else $error("masked taken");
    // vectors are even and inside the table
    property p_vec_range;
        vector_load_o |-> !vector_o[0] && vector_o >= 16'hffe0 && vector_o < 16'hfffe;
    endproperty
    a_vec_range: assert property (p_vec_range) else $error("bad vector");
    // addresses outside the four registers read as zero
    property p_unmapped;
        sfr_rd_i && (sfr_addr_i < 8'h3a || sfr_addr_i > 8'h3d) |=> sfr_rdata_o == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped data");
endmodule
bind pilc_top pilc_props u_props (.mclk_i, .rst_i, .sfr_rd_i, .sfr_addr_i,
    .sfr_rdata_o, .enable_o, .busy_o, .vector_o, .push_o, .push_sel_o,
    .push_master_o, .vector_load_o);

/* tb/prioritized_interrupt_latch_control_bench.sv */
// self-checking bench for the interrupt latch controller
`timescale 1ns/1ps
`include "pilc_regs.vh"
module prioritized_interrupt_latch_control_bench;
    reg mclk_i = 0, rst_i = 1, ext_zero_pin_enable_i = 0;
    reg ext3_req_i = 0, timer3_req_i = 0, shared_level_select_i = 0;
    reg software_trap_i = 0, undefined_opcode_trap_i = 0;
    reg enable_instruction_i = 0, disable_instruction_i = 0;
    reg return_maskable_i = 0, return_nonmaskable_i = 0;
    reg sfr_wr_i = 0, sfr_rd_i = 0;
    reg [7:0] sfr_addr_i = 0, sfr_wdata_i = 0;
    reg [15:0] src_req_i = 0;
    wire instr_done_i, stacked_master_i, irq_o, busy_o, push_o;
    wire push_master_o, vector_load_o;
    wire [1:0] push_sel_o;
    wire [7:0] sfr_rdata_o;
    wire [15:0] pending_o, enable_o, vector_o;
    reg [33:0] rows [0:7]; // source mask, trap pair, expected vector
    integer fails = 0, total_checks = 0, i;
    pilc_top dut (.mclk_i(mclk_i), .rst_i(rst_i), .src_req_i(src_req_i),
        .ext3_req_i(ext3_req_i), .timer3_req_i(timer3_req_i),
        .shared_level_select_i(shared_level_select_i),
        .ext_zero_pin_enable_i(ext_zero_pin_enable_i),
        .software_trap_i(software_trap_i),
        .undefined_opcode_trap_i(undefined_opcode_trap_i),
        .instr_done_i(instr_done_i),
        .enable_instruction_i(enable_instruction_i),
        .disable_instruction_i(disable_instruction_i),
        .return_maskable_i(return_maskable_i),
        .return_nonmaskable_i(return_nonmaskable_i),
        .stacked_master_i(stacked_master_i), .sfr_addr_i(sfr_addr_i),
        .sfr_wr_i(sfr_wr_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rd_i(sfr_rd_i),
        .sfr_rdata_o(sfr_rdata_o), .pending_o(pending_o),
        .enable_o(enable_o), .irq_o(irq_o), .busy_o(busy_o),
        .vector_o(vector_o), .push_o(push_o), .push_sel_o(push_sel_o),
        .push_master_o(push_master_o), .vector_load_o(vector_load_o));
    pilc_cpu_model u_cpu (.mclk_i(mclk_i), .rst_i(rst_i), .busy_o(busy_o),
        .push_o(push_o), .push_sel_o(push_sel_o),
        .push_master_o(push_master_o), .instr_done_o(instr_done_i),
        .stacked_master_o(stacked_master_i));
    // 25 ns clock
    initial
        forever #12.5 mclk_i = ~mclk_i;
    task check(input string name, input [15:0] seen, input [15:0] exp);
        begin
            total_checks = total_checks + 1;
            if (seen !== exp)
            begin
                fails = fails + 1;
                $display("ERROR %s expected %h seen %h", name, exp, seen);
            end
        end
    endtask
    task summarize;
        begin
            $display("checks %0d mismatches %0d", total_checks, fails);
            if (fails == 0 && total_checks > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        begin
            @(posedge mclk_i);
            {sfr_addr_i, sfr_wdata_i, sfr_wr_i} <= {a, d, 1'b1};
            @(posedge mclk_i);
            sfr_wr_i <= 1'b0;
        end
    endtask
    // read data is sampled one cycle after the strobe
    task rd_chk(input [7:0] a, input [7:0] exp);
        begin
            @(posedge mclk_i);
            {sfr_addr_i, sfr_rd_i} <= {a, 1'b1};
            @(posedge mclk_i);
            sfr_rd_i <= 1'b0;
            #1 check("sfr read", {8'h00, sfr_rdata_o}, {8'h00, exp});
        end
    endtask
    // one-cycle pulse on source lines and instruction strobes
    task pulse(input [15:0] m, input [7:0] c);
        begin
            @(posedge mclk_i);
            {src_req_i, timer3_req_i, ext3_req_i, return_nonmaskable_i,
                return_maskable_i, disable_instruction_i, enable_instruction_i,
                undefined_opcode_trap_i, software_trap_i} <= {m, c};
            @(posedge mclk_i);
            {src_req_i, timer3_req_i, ext3_req_i, return_nonmaskable_i,
                return_maskable_i, disable_instruction_i, enable_instruction_i,
                undefined_opcode_trap_i, software_trap_i} <= 24'h00_0000;
        end
    endtask
    // bounded wait for the vector load, then compare the vector
    task wait_vec(input [15:0] exp);
        integer n;
        begin
            n = 0;
            while (vector_load_o !== 1'b1 && n < 200)
            begin
                @(posedge mclk_i);
                #1 n = n + 1;
            end
            check("vector load", {15'h0, vector_load_o}, 16'h0001);
            check("vector", vector_o, exp);
            @(posedge mclk_i);
        end
    endtask
    // hang guard, well beyond the few hundred cycles used
    initial
    begin
        #500000;
        fails = fails + 1;
        summarize;
    end
    initial
    begin
        rows[0] = {16'h0004, 2'h0, `PILC_VEC_TRAP};
        rows[1] = {16'h0008, 2'h0, `PILC_VEC_WDOG};
        rows[2] = {16'h0010, 2'h0, `PILC_VEC_EXT0};
        rows[3] = {16'h0020, 2'h0, 16'hfff4};
        rows[4] = {16'h0200, 2'h0, 16'hffec};
        rows[5] = {16'h8000, 2'h0, 16'hffe0};
        rows[6] = {16'h0000, 2'h1, `PILC_VEC_SWTRAP};
        rows[7] = {16'h0000, 2'h2, `PILC_VEC_SWTRAP};
        repeat (16) @(posedge mclk_i);
        rst_i <= 1'b0;
        ext_zero_pin_enable_i <= 1'b1;
        #1 check("reset vector", vector_o, `PILC_VEC_RESET);
        for (i = 0; i < 4; i = i + 1)
            rd_chk(8'h3a + i[7:0], 8'h00);
        rd_chk(8'h3e, 8'h00);
        for (i = 0; i < 8; i = i + 1)
        begin
            wr(8'h3b, 8'hff);
            wr(8'h3a, 8'hf1);
            pulse(rows[i][33:18], {6'h00, rows[i][17:16]});
            wait_vec(rows[i][15:0]);
        end
        rd_chk(8'h3b, 8'hff);
        pulse(16'h0000, 8'h20);
        repeat (3) @(posedge mclk_i);
        #1 check("master", {15'h0, enable_o[0]}, 16'h0001);
        pulse(16'h0000, 8'h08);
        repeat (3) @(posedge mclk_i);
        #1 check("master", {15'h0, enable_o[0]}, 16'h0000);
        // master off before touching latches
        pulse(16'h0020, 8'h00);
        repeat (40) @(posedge mclk_i);
        #1 check("irq", {15'h0, irq_o}, 16'h0000);
        rd_chk(8'h3c, 8'h20);
        wr(8'h3c, 8'hff);
        rd_chk(8'h3c, 8'h20);
        wr(8'h3c, 8'hdf);
        rd_chk(8'h3c, 8'h00);
        pulse(16'h0020, 8'h04);
        wait_vec(16'hfff4);
        rd_chk(8'h3c, 8'h00);
        pulse(16'h0220, 8'h00);
        pulse(16'h0000, 8'h04);
        wait_vec(16'hfff4);
        pulse(16'h0000, 8'h04);
        wait_vec(16'hffec);
        shared_level_select_i <= 1'b1;
        repeat (4) @(posedge mclk_i);
        pulse(16'h0000, 8'h40);
        rd_chk(8'h3d, 8'h00);
        pulse(16'h0000, 8'h80);
        pulse(16'h0000, 8'h04);
        wait_vec(16'hffe2);
        pulse(16'h0008, 8'h00);
        wait_vec(`PILC_VEC_WDOG);
        rst_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
        rst_i <= 1'b0;
        #1 check("enable", enable_o, `PILC_EN_RESET);
        check("pending", pending_o, `PILC_PL_RESET);
        summarize;
    end
endmodule

/* verilog/pilc_prio.v */
// fixed priority picker over the pending requests
`timescale 1ns/1ps
`include "pilc_regs.vh"
module pilc_prio
(
    input wire [15:0] req_i,
    input wire sw_req_i,
    output reg found_o,
    output reg [3:0] idx_o,
    output reg [15:0] vec_o
)
;
    integer i;
    // lowest index wins; software trap is examined before latched sources
    always @*
    begin
        found_o = 1'b0;
        idx_o = 4'h0;
        vec_o = `PILC_VEC_RESET;
        if (sw_req_i)
        begin
            found_o = 1'b1;
            idx_o = 4'h0;
            vec_o = `PILC_VEC_SWTRAP; // R5
        end
        else
        begin
            for (i = 15; i >= 2; i = i - 1)
            begin
                if (req_i[i])
                begin
                    found_o = 1'b1;
                    idx_o = i[3:0];
                    // vectors step down by two per index  R25
                    vec_o = `PILC_VEC_RESET - {i[14:0], 1'b0};
                end
            end
        end
    end
endmodule

/* verilog/pilc_top.v */
// prioritized interrupt latch and enable control for the cpu core
`timescale 1ns/1ps
`include "pilc_regs.vh"
// How it works
// (R1) fifteen sources, nested, priority ordered
// (R2) four internal sources ignore enable register
// (R3) request sets latch; presented when enabled
// (R4) fixed hardware priority; non-maskables unranked; code ranks them, software trap first, then latch two over latch three
// (R5) software and undefined traps share vector
// (R6) address trap uses latch two
// (R7) watchdog uses latch three
// (R8) ext zero needs master, bit four, pin
// (R9) shared level fifteen routed by select bit; code routes it to latch fourteen
// (R10) accepted latch cleared on acceptance
// (R11) reset clears latches and all enables
// (R12) latches readable; write zero clears only
// (R13) software keeps bits two, three as one
// (R14) enable register fully readable and writable
// (R15) master enable low blocks maskable sources
// (R16) push master enable, then clear it
// (R17) return instructions reload stacked master enable
// (R18) master enable is bit zero, ei/di
// (R19) bits four to fifteen enable sources
// (R20) software disables before editing enables
// (R21) trap as interrupt needs select cleared
// (R22) watchdog as interrupt needs select cleared
// (R23) acceptance takes eight machine cycles
// (R24) push status, pc high, pc low
// (R25) maskable vectors descend by two
module pilc_top
(
    input wire mclk_i,
    input wire rst_i,
    input wire [15:0] src_req_i, // raw source pulses, bit = latch index
    input wire ext3_req_i, // external three request
    input wire timer3_req_i, // timer three request
    input wire shared_level_select_i, // 0 pin, 1 timer
    input wire ext_zero_pin_enable_i, // pin input enable for ext zero
    input wire software_trap_i, // software interrupt instruction
    input wire undefined_opcode_trap_i, // undefined opcode executed
    input wire instr_done_i, // current instruction completed
    input wire enable_instruction_i, // ei
    input wire disable_instruction_i, // di
    input wire return_maskable_i, // return_maskable
    input wire return_nonmaskable_i, // return_nonmaskable
    input wire stacked_master_i, // master enable popped from stack
    input wire [7:0] sfr_addr_i, // special register address
    input wire sfr_wr_i, // write strobe
    input wire [7:0] sfr_wdata_i, // write byte
    input wire sfr_rd_i, // read strobe
    output reg [7:0] sfr_rdata_o, // read byte, valid cycle after strobe
    output reg [15:0] pending_o, // pending latches
    output reg [15:0] enable_o, // enable register image
    output reg irq_o, // request presented to cpu
    output reg busy_o, // acceptance sequence running
    output reg [15:0] vector_o, // accepted vector
    output reg push_o, // one-cycle push strobe
    output reg [1:0] push_sel_o, // 0 status, 1 pc high, 2 pc low
    output reg push_master_o, // master enable value pushed
    output reg vector_load_o // pulse: load vector into pc
)
;
    // one-hot acceptance states
    localparam ST_IDLE = 4'b0001;
    localparam ST_PUSH = 4'b0010;
    localparam ST_WAIT = 4'b0100;
    localparam ST_VECT = 4'b1000;

    reg [15:0] pl_q; // pending latches
    reg [15:0] pl_d;
    reg [15:0] en_q; // enable flags plus master enable at bit 0
    reg [15:0] en_d;
    reg [3:0] st_q; // acceptance state
    reg [3:0] st_d;
    reg [3:0] cnt_q; // cycles into acceptance
    reg [3:0] cnt_d;
    reg [15:0] vec_q;
    reg saved_q; // master enable saved at acceptance
    reg sw_q; // software or undefined trap waiting
    reg [1:0] ext0_s_q; // two-stage sync of pin enable
    reg [1:0] sel_s_q;
    reg [15:0] raw_req;
    reg [15:0] ok_req;
    wire found;
    wire [3:0] pick;
    wire [15:0] pick_vec;

    // byte mask returned for a write to one half
    function [15:0] pilc_half;
        input [7:0] data;
        input hi;
        begin
            pilc_half = hi ? {data, 8'h00} : {8'h00, data};
        end
    endfunction

    // pin-side enables cross in through two flops before use
    always @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ext0_s_q <= 2'h0;
            sel_s_q <= 2'h0;
        end
        else
        begin
            ext0_s_q <= {ext0_s_q[0], ext_zero_pin_enable_i};
            sel_s_q <= {sel_s_q[0], shared_level_select_i};
        end
    end

    // raw requests; the unselected shared source is simply not held  R9
    always @*
    begin
        raw_req = src_req_i;
        raw_req[1:0] = 2'h0; // no latch for the traps below bit 2  R5
        raw_req[`PILC_BIT_SHARED] = sel_s_q[1] ? timer3_req_i : ext3_req_i;
        if (!ext0_s_q[1])
            raw_req[`PILC_BIT_EXT0] = 1'b0; // pin enable gates ext zero  R8
    end

    // acceptable requests: traps always, maskables via master and flag
    always @*
    begin
        ok_req = pl_q & en_q & {16{en_q[`PILC_BIT_MASTER]}}; // R15 R19
        ok_req[`PILC_BIT_TRAP] = pl_q[`PILC_BIT_TRAP]; // R2 R6
        ok_req[`PILC_BIT_WDOG] = pl_q[`PILC_BIT_WDOG]; // R7
        ok_req[1:0] = 2'h0;
    end

    pilc_prio u_prio
    (
        .req_i(ok_req),
        .sw_req_i(sw_q),
        .found_o(found),
        .idx_o(pick),
        .vec_o(pick_vec)
    );

    // latch, enable and sequencer next state
    always @*
    begin
        pl_d = pl_q;
        en_d = en_q;
        st_d = st_q;
        cnt_d = cnt_q;
        // software writes: zero clears a latch, one never sets  R12
        if (sfr_wr_i && sfr_addr_i == `PILC_ADDR_PL_LO)
            pl_d = pl_d & (pilc_half(sfr_wdata_i, 1'b0) | 16'hff00);
        if (sfr_wr_i && sfr_addr_i == `PILC_ADDR_PL_HI)
            pl_d = pl_d & (pilc_half(sfr_wdata_i, 1'b1) | 16'h00ff);
        // full read/write enable register  R14 R18
        if (sfr_wr_i && sfr_addr_i == `PILC_ADDR_EN_LO)
            en_d[7:0] = sfr_wdata_i;
        if (sfr_wr_i && sfr_addr_i == `PILC_ADDR_EN_HI)
            en_d[15:8] = sfr_wdata_i;
        if (enable_instruction_i)
            en_d[`PILC_BIT_MASTER] = 1'b1; // R18
        if (disable_instruction_i)
            en_d[`PILC_BIT_MASTER] = 1'b0;
        if (return_maskable_i || return_nonmaskable_i)
            en_d[`PILC_BIT_MASTER] = stacked_master_i; // R17
        case (st_q)
            ST_IDLE:
            begin
                cnt_d = 4'h0;
                if (instr_done_i && found) // R1 R4
                begin
                    st_d = ST_PUSH;
                    en_d[`PILC_BIT_MASTER] = 1'b0; // saved first  R16
                    if (!sw_q)
                        pl_d[pick] = 1'b0; // R10
                end
            end
            ST_PUSH:
            begin
                cnt_d = cnt_q + 4'h1;
                if (cnt_q == 4'h2)
                    st_d = ST_WAIT; // three pushes done  R24
            end
            ST_WAIT:
            begin
                cnt_d = cnt_q + 4'h1;
                if (cnt_q == `PILC_ACCEPT_CYCLES - 4'h3)
                    st_d = ST_VECT; // R23
            end
            ST_VECT:
            begin
                st_d = ST_IDLE;
            end
            default:
            begin
                st_d = ST_IDLE;
            end
        endcase
        // new requests set latches; set wins over any clear  R3
        pl_d = pl_d | raw_req;
    end

    // state registers  R11
    always @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            pl_q <= `PILC_PL_RESET;
            en_q <= `PILC_EN_RESET;
            st_q <= ST_IDLE;
            cnt_q <= 4'h0;
            vec_q <= `PILC_VEC_RESET;
            saved_q <= 1'b0;
            sw_q <= 1'b0;
        end
        else
        begin
            pl_q <= pl_d;
            en_q <= en_d;
            st_q <= st_d;
            cnt_q <= cnt_d;
            if (st_q == ST_IDLE && instr_done_i && found)
            begin
                vec_q <= pick_vec;
                saved_q <= en_q[`PILC_BIT_MASTER]; // R16
                sw_q <= software_trap_i || undefined_opcode_trap_i;
            end
            else if (software_trap_i || undefined_opcode_trap_i)
                sw_q <= 1'b1; // R5
        end
    end

    // registered outputs toward the core
    always @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            sfr_rdata_o <= 8'h00;
            pending_o <= `PILC_PL_RESET;
            enable_o <= `PILC_EN_RESET;
            irq_o <= 1'b0;
            busy_o <= 1'b0;
            vector_o <= `PILC_VEC_RESET;
            push_o <= 1'b0;
            push_sel_o <= 2'h0;
            push_master_o <= 1'b0;
            vector_load_o <= 1'b0;
        end
        else
        begin
            // readback; undecoded addresses read zero  R12 R14
            sfr_rdata_o <= 8'h00;
            if (sfr_rd_i)
            begin
                case (sfr_addr_i)
                    `PILC_ADDR_EN_LO: sfr_rdata_o <= en_q[7:0];
                    `PILC_ADDR_EN_HI: sfr_rdata_o <= en_q[15:8];
                    `PILC_ADDR_PL_LO: sfr_rdata_o <= pl_q[7:0];
                    `PILC_ADDR_PL_HI: sfr_rdata_o <= pl_q[15:8];
                    default: sfr_rdata_o <= 8'h00;
                endcase
            end
            pending_o <= pl_q;
            enable_o <= en_q;
            irq_o <= found;
            busy_o <= (st_d != ST_IDLE);
            push_o <= (st_q == ST_PUSH);
            push_sel_o <= cnt_q[1:0];
            push_master_o <= saved_q;
            vector_load_o <= (st_q == ST_VECT);
            if (st_q == ST_VECT)
                vector_o <= vec_q;
        end
    end
endmodule
